// file: pkg/aea_map.svh
`ifndef AEA_MAP_SVH
`define AEA_MAP_SVH

// Register offsets
`define AEA_OFS_MODE_CONTROL_TWO 8'h0c
`define AEA_OFS_WAVEFORM_SOURCE_SELECT 8'h0d
`define AEA_OFS_NOLOAD_THRESHOLD_CONFIG 8'h0e
`define AEA_OFS_METER_IRQ_ENABLE_LOW 8'hd9
`define AEA_OFS_METER_IRQ_ENABLE_MID 8'hda
`define AEA_OFS_METER_IRQ_ENABLE_HIGH 8'hdb
`define AEA_OFS_METER_IRQ_STATUS_LOW 8'hdc
`define AEA_OFS_METER_IRQ_STATUS_MID 8'hdd
`define AEA_OFS_METER_IRQ_STATUS_HIGH 8'hde
`define AEA_OFS_APPARENT_GAIN 8'h40
`define AEA_OFS_APPARENT_ENERGY 8'h41
`define AEA_OFS_APPARENT_ENERGY_DIVIDER 8'h42
`define AEA_OFS_APPARENT_ENERGY_READ_RESET 8'h43
`define AEA_OFS_HALF_CYCLE_COUNT 8'h44
`define AEA_OFS_LINE_APPARENT_ENERGY 8'h45

// Field positions
`define AEA_BIT_PULSE1_SEL_LO 0
`define AEA_BIT_AMP_HOUR_SELECT 3
`define AEA_BIT_PULSE2_SEL_LO 4
`define AEA_BIT_WAVE_SRC_LO 0
`define AEA_BIT_WAVE_RATE_LO 3
`define AEA_WAVE_SRC_APPARENT 3'h4
`define AEA_BIT_APPARENT_NOLOAD_LO 4
`define AEA_BIT_NOLOAD_FLAG 2
`define AEA_BIT_HALF_FULL 4
`define AEA_BIT_OVERFLOW 5
`define AEA_BIT_CYCLE_END 2
`define AEA_BIT_WAVE_SAMPLE_ENABLE 5

// Reset values
`define AEA_RST_BYTE 8'h00
`define AEA_RST_GAIN 12'h000
`define AEA_RST_HALF_CYCLES 16'h0000

// Gain scale and no-load levels (0.030, 0.015, 0.0075 % of 24-bit full scale)
`define AEA_GAIN_UNITY 14'sh1000
`define AEA_GAIN_SHIFT 12
`define AEA_NOLOAD_THR_1 24'h0013a9
`define AEA_NOLOAD_THR_2 24'h0009d4
`define AEA_NOLOAD_THR_3 24'h0004ea

// Timing
`define AEA_CLK_HZ 20000000
`define AEA_CLK_PERIOD_NS 50
`define AEA_SAMPLE_PERIOD_NS 1220
`define AEA_WAVE_BASE_SPS 25600

`endif

// file: pkg/aea_pkg.sv
package aea_pkg;

    typedef enum logic [1:0] {
        line_wait_zx = 2'b01,
        line_run = 2'b10
    } aea_line_state_t;

    typedef logic signed [47:0] aea_acc_t;
    typedef logic signed [25:0] aea_power_t;

endpackage

// file: design/aea_gain.sv
`timescale 1ns/1ps
`include "aea_map.svh"

module aea_gain (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Source and calibration
    input wire logic [23:0] src,
    input wire logic [11:0] gain,
    // Scaled result
    output aea_pkg::aea_power_t pwr_r
);

    logic signed [13:0] factor;
    logic signed [38:0] product;

    // Factor stays positive: 4096 plus a 12-bit signed step
    assign factor = `AEA_GAIN_UNITY + 14'($signed(gain));
    assign product = $signed({15'h0000, src}) * 39'(factor);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pwr_r <= '0;
        end else begin
            pwr_r <= 26'(product >>> `AEA_GAIN_SHIFT); // R2
        end
    end

    a_gain_unity: assert property (@(posedge core_clk) disable iff (!reset_n)
        (gain == 12'h000) |=> (pwr_r == $signed({2'h0, $past(src)}))) // R2
        else $error("unity gain does not pass source through");

endmodule

// file: design/aea_apparent_energy.sv
`timescale 1ns/1ps
`include "aea_map.svh"

// Function
// R1 - Apparent power waveform samples at 25.6, 12.8, 6.4 or 3.2 kSPS when selected.
// R2 - Scale power by one plus signed 12-bit gain over 4096.
// R3 - Apparent power is voltage rms times current rms, no post offset.
// R4 - Add power into 48-bit accumulator; upper 24 bits form energy register.
// R5 - Accumulate one sample per fixed sample period.
// R6 - Accumulator addition is signed.
// R7 - Divide accumulator by 8-bit divider first; zero divides by one.
// R8 - Read-reset energy register clears itself on each read.
// R9 - Unsigned energy raises half-full and overflow events, each interrupt-enabled.
// R10 - Active-low pulse output follows gained apparent power or current rms.
// R11 - Line energy always integrates over whole half cycles from zero crossings.
// R12 - Half-cycle count is unsigned 16 bits, up to 65535.
// R13 - Cycle end sets its status flag and interrupts when enabled.
// R14 - Writing half-cycle count clears line energy and restarts at next crossing.
// R15 - Line energy uses same path and bit weight as energy register.
// R16 - Below no-load threshold: stop accumulating, set flag, interrupt until cleared.
// R17 - Two-bit threshold field: off, 0.030, 0.015, 0.0075 percent.
// R18 - Current rms pulse output uses the same no-load threshold.
// R19 - Mode bit 3 switches all energy paths to current rms.
// R20 - Ampere-hour mode keeps the same chain and calibration registers.
// R21 - Software clears a status flag by writing zero; interrupt holds till then.
// R22 - Pulse source select: 00 active, 01 reactive, 1x apparent or current rms.
// R23 - Apparent versus current rms choice is shared by both pulse outputs.
// R24 - Half-full on energy MSB rising; overflow when energy wraps past maximum.
// R25 - Gain, divider and half-cycle count reset to zero.

module aea_apparent_energy #(
    parameter int WAVE_BASE_CYCLES = `AEA_CLK_HZ / `AEA_WAVE_BASE_SPS
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [23:0] reg_wdata,
    input wire logic reg_rd,
    output logic [23:0] reg_rdata_r,
    // Measurement inputs
    input wire logic [23:0] vrms,
    input wire logic [23:0] irms,
    input wire logic zero_cross,
    input wire logic active_lsb_pulse,
    input wire logic reactive_lsb_pulse,
    // Outputs
    output logic [1:0] pulse_n_r,
    output logic [25:0] wave_data_r,
    output logic wave_valid_r,
    output logic irq_r
);

    localparam int ACC_CYCLES = `AEA_SAMPLE_PERIOD_NS / `AEA_CLK_PERIOD_NS;

    if (WAVE_BASE_CYCLES < 2 || WAVE_BASE_CYCLES > 1023) begin : g_bad_rate
        $error("WAVE_BASE_CYCLES out of range");
    end

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [23:0] div_upper(input logic [47:0] acc, input logic [7:0] dv);
        logic [47:0] q;
        q = acc / {40'h0, (dv == 8'h00) ? 8'h01 : dv}; // R7
        return q[47:24]; // R4
    endfunction

    function automatic logic [7:0] clear_on_zero(input logic [7:0] st, input logic [7:0] wd,
                                                 input logic wr, input logic [7:0] set);
        return (wr ? (st & wd) : st) | set; // R21
    endfunction

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic [7:0] mode_control_two_r, wave_sel_r, nl_cfg_r, en_lo_r, en_mid_r, en_hi_r;
    logic [7:0] st_lo_r, st_mid_r, st_hi_r, div_r;
    logic [11:0] gain_r;
    logic [15:0] half_cycles_r;
    logic [7:0] set_lo, set_mid, set_hi;

    logic wr_half_cycle_count, rd_rr;
    assign wr_half_cycle_count = reg_wr && (reg_addr == `AEA_OFS_HALF_CYCLE_COUNT);
    assign rd_rr = reg_rd && (reg_addr == `AEA_OFS_APPARENT_ENERGY_READ_RESET);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_control_two_r <= `AEA_RST_BYTE;
            wave_sel_r <= `AEA_RST_BYTE;
            nl_cfg_r <= `AEA_RST_BYTE;
            en_lo_r <= `AEA_RST_BYTE;
            en_mid_r <= `AEA_RST_BYTE;
            en_hi_r <= `AEA_RST_BYTE;
            gain_r <= `AEA_RST_GAIN; // R25
            div_r <= `AEA_RST_BYTE;
            half_cycles_r <= `AEA_RST_HALF_CYCLES;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `AEA_OFS_MODE_CONTROL_TWO: mode_control_two_r <= reg_wdata[7:0];
                `AEA_OFS_WAVEFORM_SOURCE_SELECT: wave_sel_r <= reg_wdata[7:0];
                `AEA_OFS_NOLOAD_THRESHOLD_CONFIG: nl_cfg_r <= reg_wdata[7:0];
                `AEA_OFS_METER_IRQ_ENABLE_LOW: en_lo_r <= reg_wdata[7:0];
                `AEA_OFS_METER_IRQ_ENABLE_MID: en_mid_r <= reg_wdata[7:0];
                `AEA_OFS_METER_IRQ_ENABLE_HIGH: en_hi_r <= reg_wdata[7:0];
                `AEA_OFS_APPARENT_GAIN: gain_r <= reg_wdata[11:0];
                `AEA_OFS_APPARENT_ENERGY_DIVIDER: div_r <= reg_wdata[7:0];
                `AEA_OFS_HALF_CYCLE_COUNT: half_cycles_r <= reg_wdata[15:0]; // R12
                default: ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Source, gain and no-load
    // ---------------------------------------------------------------
    logic amp_hour;
    logic [47:0] vi_product;
    logic [23:0] src;
    logic [23:0] nl_thr;
    logic [1:0] nl_mode;
    logic below;
    aea_pkg::aea_power_t pwr_r;

    assign amp_hour = mode_control_two_r[`AEA_BIT_AMP_HOUR_SELECT];
    // Rms inputs arrive offset-corrected; the product needs no offset term
    assign vi_product = vrms * irms; // R3
    // Same gain and divider serve both sources; software reloads them
    assign src = amp_hour ? irms : vi_product[47:24]; // R19 R20
    assign nl_mode = nl_cfg_r[`AEA_BIT_APPARENT_NOLOAD_LO +: 2];

    always_comb begin
        unique case (nl_mode) // R17
            2'h1: nl_thr = `AEA_NOLOAD_THR_1;
            2'h2: nl_thr = `AEA_NOLOAD_THR_2;
            2'h3: nl_thr = `AEA_NOLOAD_THR_3;
            default: nl_thr = 24'h000000;
        endcase
    end
    // Threshold applies to whichever source is selected
    assign below = (nl_mode != 2'h0) && (src < nl_thr); // R16 R18

    aea_gain u_gain (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .src(src),
        .gain(gain_r),
        .pwr_r(pwr_r)
    );

    logic below_r;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            below_r <= 1'b0;
        end else begin
            below_r <= below;
        end
    end

    // ---------------------------------------------------------------
    // Sample tick and accumulators
    // ---------------------------------------------------------------
    logic [4:0] tick_cnt_r;
    logic tick, add_en;
    assign tick = (tick_cnt_r == 5'(ACC_CYCLES - 1));
    assign add_en = tick && !below_r; // R16

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt_r <= 5'h00;
        end else begin
            tick_cnt_r <= tick ? 5'h00 : tick_cnt_r + 5'h01; // R5
        end
    end

    aea_pkg::aea_acc_t acc_r, rr_acc_r, pwr_ext;
    assign pwr_ext = 48'(pwr_r);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_r <= '0;
        end else if (add_en) begin
            acc_r <= acc_r + pwr_ext; // R4 R6
        end
    end

    // Read clears, but a sample landing in the same cycle is kept
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rr_acc_r <= '0;
        end else if (rd_rr) begin
            rr_acc_r <= add_en ? pwr_ext : '0; // R8
        end else if (add_en) begin
            rr_acc_r <= rr_acc_r + pwr_ext; // R6
        end
    end

    // ---------------------------------------------------------------
    // Energy events
    // ---------------------------------------------------------------
    logic [23:0] energy, energy_prev_r;
    logic half_full_ev, overflow_ev, energy_step;
    assign energy = div_upper(acc_r, div_r);
    // Energy treated as unsigned; MSB rising marks half full
    assign half_full_ev = energy[23] && !energy_prev_r[23]; // R9 R24
    // With divider 0 or 1 a wrap shows as MSB falling; raising the divider above 1 also drops it
    assign overflow_ev = energy_prev_r[23] && !energy[23]; // R9 R24
    assign energy_step = energy != energy_prev_r;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            energy_prev_r <= 24'h000000;
        end else begin
            energy_prev_r <= energy;
        end
    end

    // ---------------------------------------------------------------
    // Line-cycle accumulation
    // ---------------------------------------------------------------
    aea_pkg::aea_line_state_t line_state_r;
    aea_pkg::aea_acc_t line_acc_r;
    logic [15:0] hc_cnt_r;
    logic [23:0] line_energy_r;
    logic cycle_end;

    assign cycle_end = (line_state_r == aea_pkg::line_run) && zero_cross && !wr_half_cycle_count
                       && (hc_cnt_r + 16'h0001 == half_cycles_r); // R11

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            line_state_r <= aea_pkg::line_wait_zx;
            line_acc_r <= '0;
            hc_cnt_r <= 16'h0000;
            line_energy_r <= 24'h000000;
        end else if (wr_half_cycle_count) begin
            line_state_r <= aea_pkg::line_wait_zx; // R14
            line_acc_r <= '0;
            hc_cnt_r <= 16'h0000;
            line_energy_r <= 24'h000000;
        end else begin
            unique case (line_state_r)
                aea_pkg::line_wait_zx: begin
                    if (zero_cross) begin
                        line_state_r <= aea_pkg::line_run;
                        line_acc_r <= '0;
                        hc_cnt_r <= 16'h0000;
                    end
                end
                aea_pkg::line_run: begin
                    if (cycle_end) begin
                        // Next cycle starts at once; unread result is overwritten
                        line_energy_r <= div_upper(line_acc_r, div_r); // R15
                        line_acc_r <= add_en ? pwr_ext : '0;
                        hc_cnt_r <= 16'h0000;
                    end else begin
                        if (add_en) begin
                            line_acc_r <= line_acc_r + pwr_ext; // R6 R15
                        end
                        if (zero_cross) begin
                            hc_cnt_r <= hc_cnt_r + 16'h0001;
                        end
                    end
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Status and interrupt
    // ---------------------------------------------------------------
    always_comb begin
        set_lo = 8'h00;
        set_mid = 8'h00;
        set_hi = 8'h00;
        set_lo[`AEA_BIT_NOLOAD_FLAG] = tick && below_r; // R16
        set_mid[`AEA_BIT_HALF_FULL] = half_full_ev;
        set_mid[`AEA_BIT_OVERFLOW] = overflow_ev;
        set_hi[`AEA_BIT_CYCLE_END] = cycle_end; // R13
    end

    // Set wins over a clearing write in the same cycle
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_lo_r <= `AEA_RST_BYTE;
            st_mid_r <= `AEA_RST_BYTE;
            st_hi_r <= `AEA_RST_BYTE;
        end else begin
            st_lo_r <= clear_on_zero(st_lo_r, reg_wdata[7:0],
                reg_wr && reg_addr == `AEA_OFS_METER_IRQ_STATUS_LOW, set_lo); // R21
            st_mid_r <= clear_on_zero(st_mid_r, reg_wdata[7:0],
                reg_wr && reg_addr == `AEA_OFS_METER_IRQ_STATUS_MID, set_mid);
            st_hi_r <= clear_on_zero(st_hi_r, reg_wdata[7:0],
                reg_wr && reg_addr == `AEA_OFS_METER_IRQ_STATUS_HIGH, set_hi);
        end
    end

    logic [7:0] en_hi_irq;
    // Waveform enable shares the byte but is no event
    always_comb begin
        en_hi_irq = en_hi_r;
        en_hi_irq[`AEA_BIT_WAVE_SAMPLE_ENABLE] = 1'b0;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |{st_lo_r & en_lo_r, st_mid_r & en_mid_r, st_hi_r & en_hi_irq}; // R9 R13 R16
        end
    end

    // ---------------------------------------------------------------
    // Read port
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_r <= 24'h000000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `AEA_OFS_MODE_CONTROL_TWO: reg_rdata_r <= {16'h0000, mode_control_two_r};
                `AEA_OFS_WAVEFORM_SOURCE_SELECT: reg_rdata_r <= {16'h0000, wave_sel_r};
                `AEA_OFS_NOLOAD_THRESHOLD_CONFIG: reg_rdata_r <= {16'h0000, nl_cfg_r};
                `AEA_OFS_METER_IRQ_ENABLE_LOW: reg_rdata_r <= {16'h0000, en_lo_r};
                `AEA_OFS_METER_IRQ_ENABLE_MID: reg_rdata_r <= {16'h0000, en_mid_r};
                `AEA_OFS_METER_IRQ_ENABLE_HIGH: reg_rdata_r <= {16'h0000, en_hi_r};
                `AEA_OFS_METER_IRQ_STATUS_LOW: reg_rdata_r <= {16'h0000, st_lo_r};
                `AEA_OFS_METER_IRQ_STATUS_MID: reg_rdata_r <= {16'h0000, st_mid_r};
                `AEA_OFS_METER_IRQ_STATUS_HIGH: reg_rdata_r <= {16'h0000, st_hi_r};
                `AEA_OFS_APPARENT_GAIN: reg_rdata_r <= {12'h000, gain_r};
                `AEA_OFS_APPARENT_ENERGY: reg_rdata_r <= energy;
                `AEA_OFS_APPARENT_ENERGY_DIVIDER: reg_rdata_r <= {16'h0000, div_r};
                `AEA_OFS_APPARENT_ENERGY_READ_RESET: reg_rdata_r <= div_upper(rr_acc_r, div_r);
                `AEA_OFS_HALF_CYCLE_COUNT: reg_rdata_r <= {8'h00, half_cycles_r};
                `AEA_OFS_LINE_APPARENT_ENERGY: reg_rdata_r <= line_energy_r;
                default: reg_rdata_r <= 24'h000000;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Pulse outputs and waveform
    // ---------------------------------------------------------------
    logic [1:0] sel1, sel2;
    assign sel1 = mode_control_two_r[`AEA_BIT_PULSE1_SEL_LO +: 2];
    assign sel2 = mode_control_two_r[`AEA_BIT_PULSE2_SEL_LO +: 2];

    // One shared source bit: both 1x outputs follow the same quantity
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pulse_n_r <= 2'h3;
        end else begin
            pulse_n_r[0] <= ~(sel1[1] ? energy_step : // R10 R22 R23
                              (sel1[0] ? reactive_lsb_pulse : active_lsb_pulse));
            pulse_n_r[1] <= ~(sel2[1] ? energy_step :
                              (sel2[0] ? reactive_lsb_pulse : active_lsb_pulse));
        end
    end

    logic [12:0] wave_cnt_r, wave_limit;
    logic wave_on;
    assign wave_limit = 13'(WAVE_BASE_CYCLES) << wave_sel_r[`AEA_BIT_WAVE_RATE_LO +: 2];
    assign wave_on = en_hi_r[`AEA_BIT_WAVE_SAMPLE_ENABLE]
                     && (wave_sel_r[`AEA_BIT_WAVE_SRC_LO +: 3] == `AEA_WAVE_SRC_APPARENT);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wave_cnt_r <= 13'h0000;
            wave_valid_r <= 1'b0;
            wave_data_r <= 26'h0000000;
        end else begin
            wave_valid_r <= 1'b0;
            if (!wave_on || wave_cnt_r >= wave_limit - 13'h0001) begin
                wave_cnt_r <= 13'h0000;
            end else begin
                wave_cnt_r <= wave_cnt_r + 13'h0001;
            end
            if (wave_on && wave_cnt_r >= wave_limit - 13'h0001) begin
                wave_valid_r <= 1'b1; // R1
                wave_data_r <= pwr_r;
            end
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    // Cycles since the last waveform sample, saturating
    logic [12:0] wave_gap_r;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wave_gap_r <= 13'h1fff;
        end else if (wave_valid_r) begin
            wave_gap_r <= 13'h0001;
        end else if (wave_gap_r != 13'h1fff) begin
            wave_gap_r <= wave_gap_r + 13'h0001;
        end
    end

    sequence s_half_cycle_count_write;
        wr_half_cycle_count;
    endsequence

    sequence s_cycle_restart;
        ##1 (line_energy_r == 24'h000000 && line_state_r == aea_pkg::line_wait_zx);
    endsequence

    a_tick_period: assert property (@(posedge core_clk) disable iff (!reset_n) // R5
        tick |=> !tick ##23 tick)
        else $error("sample tick period wrong");
    a_rr_clear: assert property (@(posedge core_clk) disable iff (!reset_n) // R8
        (rd_rr && !add_en) |=> (rr_acc_r == 48'h0))
        else $error("read-reset energy not cleared");
    a_half_cycle_count_restart: assert property (@(posedge core_clk) disable iff (!reset_n) // R14
        s_half_cycle_count_write |-> s_cycle_restart)
        else $error("half-cycle write did not restart line energy");
    a_noload_hold: assert property (@(posedge core_clk) disable iff (!reset_n) // R16
        (tick && below_r) |=> ($stable(acc_r) && st_lo_r[`AEA_BIT_NOLOAD_FLAG]))
        else $error("accumulated below no-load threshold");
    a_cycle_flag: assert property (@(posedge core_clk) disable iff (!reset_n) // R13
        (cycle_end && en_hi_r[`AEA_BIT_CYCLE_END]) |=> st_hi_r[`AEA_BIT_CYCLE_END] ##1 irq_r)
        else $error("cycle end flag or interrupt missing");
    a_half_full: assert property (@(posedge core_clk) disable iff (!reset_n) // R24
        ($rose(energy[23])) |=> st_mid_r[`AEA_BIT_HALF_FULL])
        else $error("half-full flag not set");
    a_flag_sticky: assert property (@(posedge core_clk) disable iff (!reset_n) // R21
        (st_hi_r[`AEA_BIT_CYCLE_END] && !(reg_wr && reg_addr == `AEA_OFS_METER_IRQ_STATUS_HIGH))
        |=> st_hi_r[`AEA_BIT_CYCLE_END])
        else $error("status flag dropped without a write");
    a_wave_rate: assert property (@(posedge core_clk) disable iff (!reset_n) // R1
        wave_valid_r |-> (wave_gap_r >= wave_limit))
        else $error("waveform samples too close");
    a_pulse_cause: assert property (@(posedge core_clk) disable iff (!reset_n) // R10
        (!pulse_n_r[0] && $past(sel1[1])) |-> $past(energy_step))
        else $error("pulse without energy step");

endmodule

// file: verif/aea_rms_src.sv
`timescale 1ns/1ps

module aea_rms_src #(
    parameter int ZX_CYCLES = 200
) (
    // Clock
    input wire logic core_clk,
    // Levels asked for by the bench
    input wire logic [23:0] v_set,
    input wire logic [23:0] i_set,
    // Measurement side
    output logic [23:0] vrms = 24'h000000,
    output logic [23:0] irms = 24'h000000,
    output logic zero_cross = 1'b0,
    output logic act_p = 1'b0,
    output logic react_p = 1'b0
);
    int cnt = 0;
    // ----------------
    // Mains-like source
    // ----------------
    // Crossings run free, like a real line, so the bench cannot time them
    always @(posedge core_clk) begin
        cnt <= (cnt == ZX_CYCLES - 1) ? 0 : cnt + 1;
        vrms <= v_set;
        irms <= i_set;
        zero_cross <= (cnt == 0);
        act_p <= (cnt == 7);
        react_p <= (cnt == 90);
    end
endmodule

// file: verif/tb.sv
`timescale 1ns/1ps
`include "aea_map.svh"

module tb;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [23:0] reg_wdata = 24'h000000;
    logic [23:0] reg_rdata_r, vrms, irms, d;
    logic [23:0] v_set = 24'h000000;
    logic [23:0] i_set = 24'h000000;
    logic zero_cross, act_p, react_p, irq_r;
    logic [1:0] pulse_n_r;
    logic [25:0] wave_data;
    logic wave_valid;
    int gap;
    int mismatches = 0;
    int tests_run = 0;
    always #25 core_clk = ~core_clk;
    aea_rms_src src (.core_clk(core_clk), .v_set(v_set), .i_set(i_set), .vrms(vrms),
        .irms(irms), .zero_cross(zero_cross), .act_p(act_p), .react_p(react_p));
    aea_apparent_energy #(.WAVE_BASE_CYCLES(4)) dut (.core_clk(core_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata_r(reg_rdata_r), .vrms(vrms), .irms(irms), .zero_cross(zero_cross),
        .active_lsb_pulse(act_p), .reactive_lsb_pulse(react_p), .pulse_n_r(pulse_n_r),
        .wave_data_r(wave_data), .wave_valid_r(wave_valid), .irq_r(irq_r));
    // ----------------
    // Access tasks
    // ----------------
    task summarize;
        if (mismatches == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input string n, input logic [23:0] e, input logic [23:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [23:0] v);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        @(negedge core_clk);
    endtask
    task rd(input logic [7:0] a, output logic [23:0] v);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        @(negedge core_clk);
        v = reg_rdata_r;
    endtask
    // Two read-reset reads 240 cycles apart: always exactly 10 ticks of the 24-cycle sample period
    task energy(input logic [23:0] e, input string n);
        rd(`AEA_OFS_APPARENT_ENERGY_READ_RESET, d);
        repeat (238) @(negedge core_clk);
        rd(`AEA_OFS_APPARENT_ENERGY_READ_RESET, d);
        chk(n, e, d);
    endtask
    task wait_on(input int w, input logic e);
        int k;
        for (k = 0; k < 3000 && (w ? pulse_n_r[w - 1] : irq_r) !== e; k++)
            @(negedge core_clk);
        chk(w ? "pulse_n" : "irq", {23'h000000, e}, {23'h000000, w ? pulse_n_r[w - 1] : irq_r});
    endtask
    task wave_gap(output int g);
        int k;
        for (k = 0; k < 3000 && wave_valid !== 1'b1; k++)
            @(negedge core_clk);
        @(negedge core_clk);
        for (g = 1; g < 3000 && wave_valid !== 1'b1; g++)
            @(negedge core_clk);
    endtask
    task settle;
        repeat (60) @(negedge core_clk);
    endtask
    // ----------------
    // Sequence
    // ----------------
    initial begin
        repeat (6) @(negedge core_clk);
        reset_n = 1'b1;
        @(negedge core_clk);
        rd(`AEA_OFS_APPARENT_GAIN, d); chk("gain", 24'h000000, d);
        rd(`AEA_OFS_APPARENT_ENERGY_DIVIDER, d); chk("divider", 24'h000000, d);
        rd(`AEA_OFS_HALF_CYCLE_COUNT, d); chk("half_cycles", 24'h000000, d);
        rd(8'h77, d); chk("unmapped", 24'h000000, d);
        wr(`AEA_OFS_HALF_CYCLE_COUNT, 24'hffffff);
        rd(`AEA_OFS_HALF_CYCLE_COUNT, d); chk("half_cycles", 24'h00ffff, d);
        wr(`AEA_OFS_MODE_CONTROL_TWO, 24'h000008);
        i_set = 24'h800000;
        settle();
        energy(24'h000005, "amp_hour");
        wr(`AEA_OFS_APPARENT_ENERGY_DIVIDER, 24'h000002);
        energy(24'h000002, "divided");
        wr(`AEA_OFS_APPARENT_ENERGY_DIVIDER, 24'h000000);
        wr(`AEA_OFS_MODE_CONTROL_TWO, 24'h000000);
        v_set = 24'h800000;
        settle();
        energy(24'h000002, "apparent");
        wr(`AEA_OFS_APPARENT_GAIN, 24'h000800);
        settle();
        energy(24'h000001, "negative_gain");
        wr(`AEA_OFS_APPARENT_GAIN, 24'h000000);
        wr(`AEA_OFS_WAVEFORM_SOURCE_SELECT, 24'h00000c);
        wr(`AEA_OFS_METER_IRQ_ENABLE_HIGH, 24'h000020);
        wave_gap(gap);
        chk("wave_period", 24'h000008, gap[23:0]);
        chk("wave_data", 24'h400000, wave_data[23:0]);
        for (int s = 0; s < 3; s++) begin
            wr(`AEA_OFS_MODE_CONTROL_TWO, {16'h0000, 2'h0, s[1:0], 2'h0, s[1:0]});
            wait_on(1, 1'b0);
            wait_on(2, 1'b0);
        end
        wr(`AEA_OFS_METER_IRQ_ENABLE_HIGH, 24'h000004);
        wr(`AEA_OFS_HALF_CYCLE_COUNT, 24'h000002);
        rd(`AEA_OFS_LINE_APPARENT_ENERGY, d); chk("line_energy", 24'h000000, d);
        wait_on(0, 1'b1);
        rd(`AEA_OFS_METER_IRQ_STATUS_HIGH, d); chk("cycle_end", 24'h04, d & 24'h04);
        rd(`AEA_OFS_LINE_APPARENT_ENERGY, d); chk("line_energy", 24'h000004, d);
        wr(`AEA_OFS_METER_IRQ_STATUS_HIGH, 24'h000000);
        wait_on(0, 1'b0);
        wr(`AEA_OFS_METER_IRQ_ENABLE_HIGH, 24'h000000);
        v_set = 24'h000100;
        wr(`AEA_OFS_NOLOAD_THRESHOLD_CONFIG, 24'h000010);
        wr(`AEA_OFS_METER_IRQ_ENABLE_LOW, 24'h000004);
        wait_on(0, 1'b1);
        rd(`AEA_OFS_METER_IRQ_STATUS_LOW, d); chk("noload", 24'h04, d & 24'h04);
        energy(24'h000000, "noload_energy");
        v_set = 24'h800000;
        settle();
        wr(`AEA_OFS_METER_IRQ_STATUS_LOW, 24'h000000);
        wait_on(0, 1'b0);
        rd(`AEA_OFS_METER_IRQ_STATUS_LOW, d); chk("noload", 24'h00, d & 24'h04);
        summarize();
    end
endmodule
